// ==== design/rmp_pkg.sv ====
// Constants and types for the remappable output select block
package rmp_pkg;
	localparam int unsigned NUM_OUT_PINS = 13;
	localparam int unsigned NUM_IN_SEL = 4;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned OSEL_W = 5;
	localparam int unsigned ISEL_W = 4;
	// Byte addresses
	localparam logic [7:0] OFF_OSEL_BASE = 8'h00;
	localparam logic [7:0] OFF_CFG_CTRL = 8'h40;
	localparam logic [7:0] OFF_UNLOCK_KEY = 8'h44;
	localparam logic [7:0] OFF_CFG_WORD3 = 8'h48;
	localparam logic [7:0] OFF_ISEL_BASE = 8'h80;
	// Field positions
	localparam int unsigned REMAP_LOCK_BIT = 13;
	localparam int unsigned SINGLE_SESSION_BIT = 29;
	// Reset values
	localparam logic [4:0] OSEL_RESET = 5'h00;
	localparam logic [3:0] ISEL_RESET = 4'h0;
	localparam logic REMAP_LOCK_RESET = 1'b0;
	localparam logic SINGLE_SESSION_RESET = 1'b1;
	// Unlock keys, values arbitrary
	localparam logic [31:0] UNLOCK_KEY1 = 32'hA5A5_1234;
	localparam logic [31:0] UNLOCK_KEY2 = 32'h5A5A_4321;
	// Output select codes
	localparam logic [4:0] SEL_OFF = 5'h00;
	localparam logic [4:0] SEL_UART1_TX = 5'h01;
	localparam logic [4:0] SEL_UART2_RTS = 5'h02;
	localparam logic [4:0] SEL_SPI1_DO = 5'h03;
	localparam logic [4:0] SEL_SPI2_DO = 5'h04;
	localparam logic [4:0] SEL_OC1 = 5'h05;
	localparam logic [4:0] SEL_OC7 = 5'h06;
	localparam logic [4:0] SEL_CMP2 = 5'h07;
	localparam logic [4:0] SEL_CMP4 = 5'h08;
	localparam logic [4:0] SEL_OUTPUT_COMPARE_13 = 5'h09;
	localparam logic [4:0] SEL_UART5_RTS = 5'h0B;
	localparam logic [4:0] SEL_CAN1_TX = 5'h0C;
	localparam logic [4:0] SEL_SPI3_DO = 5'h0E;
	localparam logic [4:0] SEL_SPI4_CLK = 5'h0F;
	localparam logic [4:0] SEL_SPI5_DO = 5'h10;
	localparam logic [4:0] SEL_QEI5_CMP = 5'h15;
	// One bit per code that reaches a peripheral
	localparam logic [31:0] SEL_VALID_MASK = 32'h0021_DBFE;
	typedef struct packed {
		logic [NUM_OUT_PINS-1:0][OSEL_W-1:0] osel;
		logic [NUM_IN_SEL-1:0][ISEL_W-1:0] isel;
		logic remap_lock;
		logic single_session;
		logic session_taken;
		logic key1_seen;
		logic unlock_armed;
		logic [31:0] rdata;
	} rmp_state_t;
endpackage : rmp_pkg

// ==== design/rmp_pin_mux.sv ====
// One remappable pin: select code to peripheral output
`timescale 1ns/1ps
`default_nettype none
module rmp_pin_mux (
	input wire logic [4:0] sel, // Output select field
	input wire logic [31:0] src, // Peripheral outputs indexed by code
	output logic pin_out, // Pin data
	output logic pin_oe // Pin driven by a peripheral
);
	always_comb begin
		// Reserved and off codes leave the pin unconnected
		pin_oe = rmp_pkg::SEL_VALID_MASK[sel]; // RULE_10
		pin_out = pin_oe & src[sel]; // RULE_12
	end
endmodule : rmp_pin_mux
`default_nettype wire

// ==== design/rmp_output_select.sv ====
// Remappable pin output multiplexer with select register lock
//
// Operation
// RULE_01 - Locked select writes complete but change nothing
// RULE_02 - Lock bit 13 of config control
// RULE_03 - Lock bit changes only after unlock sequence
// RULE_04 - Single session bit blocks clearing set lock
// RULE_05 - Permanent lock: unlock ignored, reset clears
// RULE_06 - Single session bit defaults to set
// RULE_07 - Five-bit field; 0 off, 1 uart1 transmit
// RULE_08 - Codes 2 to 7 map listed peripherals
// RULE_09 - Codes 8 to 21 map listed peripherals
// RULE_10 - Reserved codes connect nothing
// RULE_11 - Output select registers reset to zero
// RULE_12 - Each pin's field picks its driver
// RULE_13 - Accepted write drives mux next cycle
`timescale 1ns/1ps
`default_nettype none
module rmp_output_select (
	input wire logic clk, // 40 MHz system clock
	input wire logic reset_n, // Asynchronous device reset
	input wire logic [7:0] addr, // Register byte address
	input wire logic [31:0] wdata, // Write data
	input wire logic wr_stb, // Write strobe
	input wire logic rd_stb, // Read strobe
	output logic [31:0] rdata, // Read data, cycle after strobe
	input wire logic [31:0] device_config_word3, // Configuration word strap
	input wire logic uart1_transmit, // Peripheral output
	input wire logic uart2_request_to_send, // Peripheral output
	input wire logic spi1_data_out, // Peripheral output
	input wire logic spi2_data_out, // Peripheral output
	input wire logic output_compare_1, // Peripheral output
	input wire logic output_compare_7, // Peripheral output
	input wire logic comparator2_output, // Peripheral output
	input wire logic comparator4_output, // Peripheral output
	input wire logic output_compare_13, // Peripheral output
	input wire logic uart5_request_to_send, // Peripheral output
	input wire logic can1_transmit, // Peripheral output
	input wire logic spi3_data_out, // Peripheral output
	input wire logic spi4_clock_out, // Peripheral output
	input wire logic spi5_data_out, // Peripheral output
	input wire logic quadrature5_compare_out, // Peripheral output
	output logic [12:0] pin_out, // Pin data per remappable pin
	output logic [12:0] pin_oe, // Pin driven per remappable pin
	output logic [15:0] input_select, // Peripheral input selects, 4 bits each
	output logic remap_lock // Current lock state
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	rmp_pkg::rmp_state_t st_q;
	rmp_pkg::rmp_state_t st_d;
	logic [31:0] src;
	logic [3:0] osel_idx;
	logic [1:0] isel_idx;
	logic hit_osel;
	logic hit_isel;
	logic hit_cfg;
	logic hit_key;
	logic hit_word3;
	logic lock_forever;

	// Reset release through two flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Address decode
	always_comb begin
		osel_idx = addr[5:2];
		isel_idx = addr[3:2];
		hit_osel = (addr[7:6] == 2'h0) && (addr[1:0] == 2'h0)
			&& (addr[5:2] < 4'(rmp_pkg::NUM_OUT_PINS));
		hit_isel = (addr[7:4] == rmp_pkg::OFF_ISEL_BASE[7:4]) && (addr[1:0] == 2'h0);
		hit_cfg = (addr == rmp_pkg::OFF_CFG_CTRL);
		hit_key = (addr == rmp_pkg::OFF_UNLOCK_KEY);
		hit_word3 = (addr == rmp_pkg::OFF_CFG_WORD3);
	end

	// Lock held until reset once set with single session on
	assign lock_forever = st_q.single_session && st_q.remap_lock; // RULE_05

	always_comb begin
		st_d = st_q;
		// Capture the strap once after reset release
		if (!st_q.session_taken) begin
			st_d.single_session = device_config_word3[rmp_pkg::SINGLE_SESSION_BIT];
			st_d.session_taken = 1'b1;
		end
		if (wr_stb) begin
			// Any write outside the key pair breaks the sequence
			st_d.key1_seen = 1'b0;
			if (hit_osel && !st_q.remap_lock) begin // RULE_01
				st_d.osel[osel_idx] = wdata[4:0]; // RULE_07 RULE_13
			end
			if (hit_isel && !st_q.remap_lock) begin // RULE_01
				st_d.isel[isel_idx] = wdata[3:0];
			end
			if (hit_key) begin
				if (wdata == rmp_pkg::UNLOCK_KEY1) begin
					st_d.key1_seen = 1'b1;
				end else if (st_q.key1_seen && wdata == rmp_pkg::UNLOCK_KEY2) begin
					st_d.unlock_armed = !lock_forever; // RULE_03 RULE_05
				end else begin
					st_d.unlock_armed = 1'b0;
				end
			end
			if (hit_cfg) begin
				// An armed sequence is spent by the next control write
				st_d.unlock_armed = 1'b0;
				if (st_q.unlock_armed) begin // RULE_03
					if (wdata[rmp_pkg::REMAP_LOCK_BIT]) begin // RULE_02
						st_d.remap_lock = 1'b1;
					end else if (!lock_forever) begin // RULE_04
						st_d.remap_lock = 1'b0;
					end
				end
			end
		end
		st_d.rdata = 32'h0000_0000;
		if (rd_stb) begin
			if (hit_osel) begin
				st_d.rdata = {27'h0, st_q.osel[osel_idx]};
			end else if (hit_isel) begin
				st_d.rdata = {28'h0000000, st_q.isel[isel_idx]};
			end else if (hit_cfg) begin
				st_d.rdata[rmp_pkg::REMAP_LOCK_BIT] = st_q.remap_lock;
			end else if (hit_word3) begin
				st_d.rdata[rmp_pkg::SINGLE_SESSION_BIT] = st_q.single_session;
			end else begin
				st_d.rdata = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < rmp_pkg::NUM_OUT_PINS; i++) begin
				st_q.osel[i] <= rmp_pkg::OSEL_RESET; // RULE_11
			end
			for (int i = 0; i < rmp_pkg::NUM_IN_SEL; i++) begin
				st_q.isel[i] <= rmp_pkg::ISEL_RESET;
			end
			st_q.remap_lock <= rmp_pkg::REMAP_LOCK_RESET; // RULE_05
			st_q.single_session <= rmp_pkg::SINGLE_SESSION_RESET; // RULE_06
			st_q.session_taken <= 1'b0;
			st_q.key1_seen <= 1'b0;
			st_q.unlock_armed <= 1'b0;
			st_q.rdata <= 32'h0000_0000;
		end else begin
			st_q <= st_d;
		end
	end

	// Peripheral outputs placed at their select codes
	always_comb begin
		src = 32'h0000_0000;
		src[rmp_pkg::SEL_UART1_TX] = uart1_transmit; // RULE_07
		src[rmp_pkg::SEL_UART2_RTS] = uart2_request_to_send; // RULE_08
		src[rmp_pkg::SEL_SPI1_DO] = spi1_data_out; // RULE_08
		src[rmp_pkg::SEL_SPI2_DO] = spi2_data_out; // RULE_08
		src[rmp_pkg::SEL_OC1] = output_compare_1; // RULE_08
		src[rmp_pkg::SEL_OC7] = output_compare_7; // RULE_08
		src[rmp_pkg::SEL_CMP2] = comparator2_output; // RULE_08
		src[rmp_pkg::SEL_CMP4] = comparator4_output; // RULE_09
		src[rmp_pkg::SEL_OUTPUT_COMPARE_13] = output_compare_13; // RULE_09
		src[rmp_pkg::SEL_UART5_RTS] = uart5_request_to_send; // RULE_09
		src[rmp_pkg::SEL_CAN1_TX] = can1_transmit; // RULE_09
		src[rmp_pkg::SEL_SPI3_DO] = spi3_data_out;
		src[rmp_pkg::SEL_SPI4_CLK] = spi4_clock_out; // RULE_09
		src[rmp_pkg::SEL_SPI5_DO] = spi5_data_out; // RULE_09
		src[rmp_pkg::SEL_QEI5_CMP] = quadrature5_compare_out; // RULE_09
	end

	genvar g;
	generate
		for (g = 0; g < rmp_pkg::NUM_OUT_PINS; g++) begin : g_pin
			rmp_pin_mux u_mux (
				.sel(st_q.osel[g]),
				.src(src),
				.pin_out(pin_out[g]),
				.pin_oe(pin_oe[g])
			); // RULE_12
		end
		for (g = 0; g < rmp_pkg::NUM_IN_SEL; g++) begin : g_isel
			assign input_select[4*g+3:4*g] = st_q.isel[g];
		end
	endgenerate

	assign rdata = st_q.rdata;
	assign remap_lock = st_q.remap_lock;

	// Checks
	property p_locked_write_kept;
		@(posedge clk) disable iff (!rst_n)
		(wr_stb && hit_osel && st_q.remap_lock) |=> (st_q.osel == $past(st_q.osel));
	endproperty
	a_locked_write_kept: assert property (p_locked_write_kept) // RULE_01
		else $error("Select changed while locked");

	property p_open_write_taken;
		@(posedge clk) disable iff (!rst_n)
		(wr_stb && hit_osel && !st_q.remap_lock)
			|=> (st_q.osel[$past(osel_idx)] == $past(wdata[4:0]));
	endproperty
	a_open_write_taken: assert property (p_open_write_taken) // RULE_13
		else $error("Unlocked select write not stored");

	property p_lock_readback;
		@(posedge clk) disable iff (!rst_n)
		(rd_stb && hit_cfg) |=> (rdata[rmp_pkg::REMAP_LOCK_BIT] == $past(st_q.remap_lock));
	endproperty
	a_lock_readback: assert property (p_lock_readback) // RULE_02
		else $error("Lock bit not at bit 13");

	property p_lock_needs_unlock;
		@(posedge clk) disable iff (!rst_n)
		!st_q.unlock_armed |=> $stable(st_q.remap_lock);
	endproperty
	a_lock_needs_unlock: assert property (p_lock_needs_unlock) // RULE_03
		else $error("Lock changed without unlock sequence");

	property p_single_session_hold;
		@(posedge clk) disable iff (!rst_n)
		(st_q.single_session && st_q.remap_lock) |=> st_q.remap_lock;
	endproperty
	a_single_session_hold: assert property (p_single_session_hold) // RULE_04
		else $error("Lock cleared under single session");

	property p_no_arm_when_forever;
		@(posedge clk) disable iff (!rst_n)
		lock_forever |=> !st_q.unlock_armed;
	endproperty
	a_no_arm_when_forever: assert property (p_no_arm_when_forever) // RULE_05
		else $error("Unlock armed under permanent lock");

	property p_session_default;
		@(posedge clk)
		$rose(rst_n) |-> st_q.single_session;
	endproperty
	a_session_default: assert property (p_session_default) // RULE_06
		else $error("Single session not set after reset");

	property p_reset_off;
		@(posedge clk)
		$rose(rst_n) |-> (pin_oe == 13'h0);
	endproperty
	a_reset_off: assert property (p_reset_off) // RULE_11
		else $error("Pin driven after reset");

	property p_reserved_off;
		@(posedge clk) disable iff (!rst_n)
		(st_q.osel[0] == 5'h0A || st_q.osel[0] == 5'h0D || st_q.osel[0] >= 5'h16
			|| st_q.osel[0] == 5'h00) |-> !pin_oe[0];
	endproperty
	a_reserved_off: assert property (p_reserved_off) // RULE_10
		else $error("Reserved code drives pin");

	property p_uart1_route;
		@(posedge clk) disable iff (!rst_n)
		(st_q.osel[0] == 5'h01) |-> (pin_oe[0] && pin_out[0] == uart1_transmit);
	endproperty
	a_uart1_route: assert property (p_uart1_route) // RULE_07
		else $error("Code 1 not routing uart1 transmit");

	property p_can1_route;
		@(posedge clk) disable iff (!rst_n)
		(st_q.osel[10] == 5'h0C) |-> (pin_out[10] == can1_transmit);
	endproperty
	a_can1_route: assert property (p_can1_route) // RULE_09
		else $error("Code 12 not routing can1 transmit");

	property p_cmp2_route;
		@(posedge clk) disable iff (!rst_n)
		(st_q.osel[6] == 5'h07) |-> (pin_out[6] == comparator2_output);
	endproperty
	a_cmp2_route: assert property (p_cmp2_route) // RULE_08
		else $error("Code 7 not routing comparator 2");

	property p_uart2_route;
		@(posedge clk) disable iff (!rst_n)
		(st_q.osel[1] == 5'h02) |-> (pin_oe[1] && pin_out[1] == uart2_request_to_send);
	endproperty
	a_uart2_route: assert property (p_uart2_route) // RULE_08
		else $error("Code 2 not routing uart2 request to send");

	property p_spi1_route;
		@(posedge clk) disable iff (!rst_n)
		(st_q.osel[2] == 5'h03) |-> (pin_oe[2] && pin_out[2] == spi1_data_out);
	endproperty
	a_spi1_route: assert property (p_spi1_route) // RULE_08
		else $error("Code 3 not routing spi1 data out");

	property p_qei5_route;
		@(posedge clk) disable iff (!rst_n)
		(st_q.osel[0] == 5'h15) |-> (pin_oe[0] && pin_out[0] == quadrature5_compare_out);
	endproperty
	a_qei5_route: assert property (p_qei5_route) // RULE_09
		else $error("Code 21 not routing quadrature 5 compare");

	property p_locked_isel_kept;
		@(posedge clk) disable iff (!rst_n)
		(wr_stb && hit_isel && st_q.remap_lock) |=> (st_q.isel == $past(st_q.isel));
	endproperty
	a_locked_isel_kept: assert property (p_locked_isel_kept) // RULE_01
		else $error("Input select changed while locked");

	property p_open_isel_taken;
		@(posedge clk) disable iff (!rst_n)
		(wr_stb && hit_isel && !st_q.remap_lock)
			|=> (st_q.isel[$past(isel_idx)] == $past(wdata[3:0]));
	endproperty
	a_open_isel_taken: assert property (p_open_isel_taken) // RULE_01
		else $error("Unlocked input select write not stored");

	property p_key_arms;
		@(posedge clk) disable iff (!rst_n)
		(wr_stb && hit_key && st_q.key1_seen && !lock_forever
			&& wdata == rmp_pkg::UNLOCK_KEY2) |=> st_q.unlock_armed;
	endproperty
	a_key_arms: assert property (p_key_arms) // RULE_03
		else $error("Key pair did not arm the lock write");

	property p_lock_set_armed;
		@(posedge clk) disable iff (!rst_n)
		(wr_stb && hit_cfg && st_q.unlock_armed && wdata[rmp_pkg::REMAP_LOCK_BIT])
			|=> st_q.remap_lock;
	endproperty
	a_lock_set_armed: assert property (p_lock_set_armed) // RULE_02
		else $error("Armed lock set not taken");

	property p_lock_clear_armed;
		@(posedge clk) disable iff (!rst_n)
		(wr_stb && hit_cfg && st_q.unlock_armed && !lock_forever
			&& !wdata[rmp_pkg::REMAP_LOCK_BIT]) |=> !st_q.remap_lock;
	endproperty
	a_lock_clear_armed: assert property (p_lock_clear_armed) // RULE_03
		else $error("Armed lock clear not taken");

	property p_forever_stays;
		@(posedge clk) disable iff (!rst_n)
		lock_forever |=> lock_forever;
	endproperty
	a_forever_stays: assert property (p_forever_stays) // RULE_05
		else $error("Permanent lock released before reset");

	c_lock_set: cover property (@(posedge clk) disable iff (!rst_n) $rose(st_q.remap_lock));
	c_lock_clear: cover property (@(posedge clk) disable iff (!rst_n) $fell(st_q.remap_lock));
	c_locked_write: cover property (@(posedge clk) disable iff (!rst_n)
		wr_stb && hit_osel && st_q.remap_lock);
	c_pin_routed: cover property (@(posedge clk) disable iff (!rst_n) pin_oe[0]);
endmodule : rmp_output_select
`default_nettype wire

// ==== test/rmp_periph_model.sv ====
// Peripheral output levels indexed by output select code
`timescale 1ns/1ps
`default_nettype none
module rmp_periph_model (
	input wire logic [31:0] pat, // Wanted level per select code
	output logic [31:0] src // Peripheral outputs, bit k for code k
);
	// Every code gets its own level so a wrong route shows
	assign src = pat;
endmodule : rmp_periph_model
`default_nettype wire

// ==== test/rmp_output_select_test.sv ====
// Self-checking bench for the remappable output select block
`timescale 1ns/1ps
`default_nettype none
module rmp_output_select_test;
	localparam logic [31:0] VALID = 32'h0021_DBFE;
	localparam logic [4:0] CODES [13] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
		5'h08, 5'h09, 5'h0B, 5'h0C, 5'h0E, 5'h0F};
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] strap = 32'h0;
	logic [31:0] pat = 32'h0;
	logic [31:0] src;
	logic [31:0] rdata;
	logic [12:0] pin_out;
	logic [12:0] pin_oe;
	logic [15:0] input_select;
	logic remap_lock;
	int errors = 0;
	int num_checks = 0;

	always #12.5 clk = ~clk;

	rmp_periph_model i_rmp_periph_model (.pat(pat), .src(src));
	rmp_output_select i_rmp_output_select (.clk(clk), .reset_n(reset_n), .addr(addr),
		.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.device_config_word3(strap), .uart1_transmit(src[1]), .uart2_request_to_send(src[2]),
		.spi1_data_out(src[3]), .spi2_data_out(src[4]), .output_compare_1(src[5]),
		.output_compare_7(src[6]), .comparator2_output(src[7]), .comparator4_output(src[8]),
		.output_compare_13(src[9]), .uart5_request_to_send(src[11]), .can1_transmit(src[12]),
		.spi3_data_out(src[14]), .spi4_clock_out(src[15]), .spi5_data_out(src[16]),
		.quadrature5_compare_out(src[21]), .pin_out(pin_out), .pin_oe(pin_oe),
		.input_select(input_select), .remap_lock(remap_lock));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr_stb <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_stb <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rd

	task automatic rst(input logic [31:0] s);
		@(posedge clk);
		reset_n <= 1'b0;
		strap <= s;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
	endtask : rst

	// Two key writes arm one config control write
	task automatic unlock;
		wr(8'h44, rmp_pkg::UNLOCK_KEY1);
		wr(8'h44, rmp_pkg::UNLOCK_KEY2);
	endtask : unlock

	// Both levels on every peripheral, so a stuck route shows
	task automatic showp(input int i, input logic [4:0] c);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			pat <= (k == 0) ? 32'hA5C3_9617 : 32'h5A3C_69E8;
			#1;
			chk(32'(pin_oe[i]), 32'(VALID[c]));
			if (VALID[c])
				chk(32'(pin_out[i]), 32'(pat[c]));
		end
	endtask : showp

	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	initial begin
		#500000;
		errors++;
		conclude();
	end

	initial begin
		rst(32'h0);
		chk({19'h0, pin_oe}, 32'h0);
		for (int i = 0; i < 13; i++)
			rd(8'(4 * i), 32'h0);
		rd(8'h48, 32'h0);
		for (int c = 0; c < 32; c++) begin
			wr(8'h00, 32'hFFFF_FFE0 | 32'(c));
			chk(32'(pin_oe[0]), 32'(VALID[c]));
			showp(0, 5'(c));
			rd(8'h00, 32'(c));
		end
		for (int i = 0; i < 13; i++)
			wr(8'(4 * i), 32'(CODES[i]));
		for (int i = 0; i < 13; i++)
			showp(i, CODES[i]);
		wr(8'h84, 32'hA);
		chk(32'(input_select), 32'h00A0);
		wr(8'h40, 32'h2000);
		chk(32'(remap_lock), 32'h0);
		unlock();
		wr(8'h40, 32'h2000);
		chk(32'(remap_lock), 32'h1);
		rd(8'h40, 32'h2000);
		wr(8'h00, 32'h3);
		rd(8'h00, 32'h1);
		wr(8'h84, 32'h5);
		chk(32'(input_select), 32'h00A0);
		wr(8'h44, rmp_pkg::UNLOCK_KEY1);
		wr(8'h00, 32'h3);
		wr(8'h44, rmp_pkg::UNLOCK_KEY2);
		wr(8'h40, 32'h0);
		chk(32'(remap_lock), 32'h1);
		unlock();
		wr(8'h40, 32'h0);
		chk(32'(remap_lock), 32'h0);
		wr(8'h00, 32'h3);
		rd(8'h00, 32'h3);
		rst(32'h2000_0000);
		rd(8'h48, 32'h2000_0000);
		unlock();
		wr(8'h40, 32'h2000);
		chk(32'(remap_lock), 32'h1);
		unlock();
		wr(8'h40, 32'h0);
		chk(32'(remap_lock), 32'h1);
		wr(8'h00, 32'h5);
		rd(8'h00, 32'h0);
		rst(32'h2000_0000);
		chk(32'(remap_lock), 32'h0);
		wr(8'h00, 32'h5);
		rd(8'h00, 32'h5);
		conclude();
	end
endmodule : rmp_output_select_test
`default_nettype wire
